// >>> rtl/uart_rx_buffer_status.sv
// Serial receiver: clock recovery, bit voting, two-entry receive buffer
module uart_rx_buffer_status #(
    parameter int DEPTH = uart_rx_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic rxLine,
    input wire logic sampleTick,
    input wire uart_rx_pkg::rx_config_t cfg,
    input wire logic globalIrqEn,
    input wire logic dataRead,
    output uart_rx_pkg::rx_entry_t rxHead,
    output logic rxDoneFlag,
    output logic rxIrq,
    output logic pinOverride
);
    import uart_rx_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);

    if (DEPTH != 2 ** PW || DEPTH < 2) begin : g_bad_depth
        $error("DEPTH must be a power of two, at least two");
    end

    function automatic logic majority(input logic [2:0] s);
        majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : majority

    function automatic logic [3:0] dataBits(input logic [2:0] code);
        dataBits = (code == CHAR_SIZE_NINE) ? DATA_BITS_NINE
            : DATA_BITS_MIN + {2'b00, code[1:0]};
    endfunction : dataBits

    ////////////////////////////////////////////////////////////////////
    // Receive state

    rx_state_t state, next_state;
    logic [4:0] sampleCnt, next_sampleCnt;
    logic [1:0] votes, next_votes;
    logic [3:0] bitIdx, next_bitIdx;
    logic [8:0] shiftReg, next_shiftReg;
    logic parityBit, next_parityBit;
    logic prevLine, next_prevLine;
    rx_entry_t holdEntry, next_holdEntry;
    logic holdValid, next_holdValid;
    logic ovrSticky, next_ovrSticky;
    rx_entry_t fifo [DEPTH];
    logic [PW-1:0] rdPtr, next_rdPtr;
    logic [PW:0] count, next_count;

    wire enabled = cfg.receiverEnable;
    wire [4:0] samplesPerBit = cfg.doubleSpeed ? SAMPLES_DOUBLE
        : SAMPLES_NORMAL;
    wire [4:0] voteFirst = cfg.doubleSpeed ? VOTE_FIRST_DOUBLE
        : VOTE_FIRST_NORMAL;
    wire [4:0] voteLast = voteFirst + VOTE_SPAN;
    wire [3:0] nData = dataBits(cfg.charSizeSelect);
    wire [3:0] nBits = nData + {3'b000, cfg.parityEnable};
    wire inVote = sampleCnt >= voteFirst && sampleCnt < voteLast;
    wire voteNow = sampleTick && sampleCnt == voteLast;
    wire bitValue = majority({votes, rxLine});
    wire wrapNow = sampleTick && sampleCnt == samplesPerBit;
    wire startEdge = state == ST_IDLE && sampleTick && prevLine
        && !rxLine;
    wire frameDone = enabled && state == ST_STOP && voteNow;
    wire isNine = cfg.charSizeSelect == CHAR_SIZE_NINE;

    ////////////////////////////////////////////////////////////////////
    // Buffer control

    wire popEn = dataRead && count != '0;
    wire fullNow = count == FULL_COUNT;
    // Shifter still waiting on a full buffer when a start comes: lost
    wire ovrEvent = enabled && startEdge && fullNow && holdValid
        && !popEn;
    wire space = !fullNow || popEn;
    wire pushEn = enabled && space && (holdValid || frameDone);
    wire [PW:0] afterPop = count - {{PW{1'b0}}, popEn};
    wire [PW-1:0] wrPtr = rdPtr + afterPop[PW-1:0] + PW'(popEn);

    rx_entry_t frameEntry, pushEntry, next_head;
    assign frameEntry.data = shiftReg[7:0];
    assign frameEntry.ninth = isNine & shiftReg[NINTH_POS];
    assign frameEntry.frameErr = !bitValue;
    assign frameEntry.overrun = ovrSticky;
    // Even parity when odd select is zero
    assign frameEntry.parityErr = cfg.parityEnable
        & (^shiftReg ^ parityBit ^ cfg.parityOdd);
    assign pushEntry = holdValid ? holdEntry : frameEntry;

    always_comb begin
        next_rdPtr = rdPtr + PW'(popEn);
        next_count = afterPop + {{PW{1'b0}}, pushEn};
        if (!enabled) begin
            next_rdPtr = '0;
            next_count = '0;
        end
        if (next_count == '0) begin
            next_head = ENTRY_RESET;
        end else if (afterPop == '0) begin
            next_head = pushEntry;
        end else begin
            next_head = fifo[next_rdPtr];
        end
    end

    always_comb begin
        next_holdEntry = holdEntry;
        next_holdValid = holdValid;
        next_ovrSticky = ovrSticky;
        if (holdValid && pushEn) begin
            next_holdValid = 1'b0;
        end
        if (ovrEvent) begin
            next_holdValid = 1'b0;
            next_ovrSticky = 1'b1;
        end
        if (frameDone) begin
            next_ovrSticky = 1'b0;
            if (holdValid || !space) begin
                next_holdValid = 1'b1;
                next_holdEntry = frameEntry;
            end
        end
        if (!enabled) begin
            next_holdValid = 1'b0;
            next_ovrSticky = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Clock and data recovery

    always_comb begin
        next_state = state;
        next_sampleCnt = sampleCnt;
        next_votes = votes;
        next_bitIdx = bitIdx;
        next_shiftReg = shiftReg;
        next_parityBit = parityBit;
        next_prevLine = sampleTick ? rxLine : prevLine;
        if (sampleTick && state != ST_IDLE) begin
            next_sampleCnt = sampleCnt + SAMPLE_FIRST;
            if (inVote) begin
                next_votes = {votes[0], rxLine};
            end
        end
        unique case (state)
            ST_IDLE: begin
                // Each frame restarts the bit timing on its own edge
                if (startEdge) begin
                    next_state = ST_START;
                    next_sampleCnt = SAMPLE_FIRST;
                    next_shiftReg = '0;
                    next_parityBit = 1'b0;
                end
            end
            ST_START: begin
                if (voteNow && bitValue) begin
                    next_state = ST_IDLE;
                end else if (wrapNow) begin
                    next_state = ST_BITS;
                    next_sampleCnt = SAMPLE_FIRST;
                    next_bitIdx = '0;
                end
            end
            ST_BITS: begin
                if (voteNow && bitIdx < nData) begin
                    next_shiftReg[bitIdx] = bitValue;
                end else if (voteNow) begin
                    next_parityBit = bitValue;
                end
                if (wrapNow) begin
                    next_sampleCnt = SAMPLE_FIRST;
                    next_bitIdx = bitIdx + 4'h1;
                    if (bitIdx + 4'h1 == nBits) begin
                        next_state = ST_STOP;
                    end
                end
            end
            ST_STOP: begin
                // Leave at the vote so an early start is caught
                if (voteNow) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (!enabled) begin
            next_state = ST_IDLE;
            next_prevLine = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            sampleCnt <= SAMPLE_FIRST;
            votes <= '0;
            bitIdx <= '0;
            shiftReg <= '0;
            parityBit <= 1'b0;
            prevLine <= 1'b1;
        end else begin
            state <= next_state;
            sampleCnt <= next_sampleCnt;
            votes <= next_votes;
            bitIdx <= next_bitIdx;
            shiftReg <= next_shiftReg;
            parityBit <= next_parityBit;
            prevLine <= next_prevLine;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            holdEntry <= ENTRY_RESET;
            holdValid <= 1'b0;
            ovrSticky <= 1'b0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            holdEntry <= next_holdEntry;
            holdValid <= next_holdValid;
            ovrSticky <= next_ovrSticky;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

    // Storage needs no reset: count guards every read
    always_ff @(posedge sys_clk) begin
        if (pushEn) begin
            fifo[wrPtr] <= pushEntry;
        end
    end

    // Error flags never reach the interrupt; software has no write path
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxHead <= ENTRY_RESET;
            rxDoneFlag <= 1'b0;
            rxIrq <= 1'b0;
            pinOverride <= 1'b0;
        end else begin
            rxHead <= next_head;
            rxDoneFlag <= next_count != '0;
            rxIrq <= next_count != '0 && cfg.rxDoneIrqEn
                && globalIrqEn;
            pinOverride <= enabled;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    sequence startVotedHigh;
        state == ST_START && voteNow && bitValue;
    endsequence

    sequence headSteady;
        (count != '0 && !dataRead && enabled)[*2];
    endsequence

    done_flag_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n) rxDoneFlag == (count != '0))
        else $error("done flag disagrees with buffer level");
    flush_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n) !enabled |=> !rxDoneFlag && count == '0)
        else $error("buffer not flushed on disable");
    abandon_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n) !enabled |=> state == ST_IDLE && !holdValid)
        else $error("frame not abandoned on disable");
    irq_level_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n) rxIrq |-> rxDoneFlag
        && $past(cfg.rxDoneIrqEn) && $past(globalIrqEn))
        else $error("interrupt without its cause");
    pop_read_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n) enabled && dataRead && count == FULL_COUNT
        && !pushEn |=> count == FULL_COUNT - 1'b1)
        else $error("data read did not pop");
    head_steady_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n) headSteady |=> $stable(rxHead))
        else $error("head changed without a data read");
    overrun_set_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n) ovrEvent && !frameDone |=> ovrSticky)
        else $error("overrun not recorded");
    overrun_clr_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n) frameDone |=> !ovrSticky)
        else $error("overrun kept after transfer");
    parity_off_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        frameDone && !cfg.parityEnable |-> !frameEntry.parityErr)
        else $error("parity error while checking off");
    start_reject_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n) startVotedHigh |=> state == ST_IDLE)
        else $error("noise start not rejected");
    pin_release_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n) pinOverride == $past(enabled))
        else $error("pin override wrong");

endmodule : uart_rx_buffer_status

// >>> pkg/uart_rx_pkg.sv
// Shared constants and types of the serial receive block
package uart_rx_pkg;

    // Oversampling per bit and first voting sample
    localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
    localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
    localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
    localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
    localparam logic [4:0] VOTE_SPAN = 5'h02;
    localparam logic [4:0] SAMPLE_FIRST = 5'h01;

    // Character size codes
    localparam logic [2:0] CHAR_SIZE_NINE = 3'h7;
    localparam logic [3:0] DATA_BITS_NINE = 4'h9;
    localparam logic [3:0] DATA_BITS_MIN = 4'h5;
    localparam int NINTH_POS = 8;

    localparam int FIFO_DEPTH = 2;

    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic frameErr;
        logic overrun;
        logic parityErr;
    } rx_entry_t;

    localparam rx_entry_t ENTRY_RESET = '0;

    typedef struct packed {
        logic receiverEnable;
        logic [2:0] charSizeSelect;
        logic parityEnable;
        logic parityOdd;
        logic doubleSpeed;
        logic rxDoneIrqEn;
    } rx_config_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_START = 4'h2,
        ST_BITS = 4'h4,
        ST_STOP = 4'h8
    } rx_state_t;

endpackage : uart_rx_pkg

// >>> bench/serial_tx_model.sv
// Remote serial transmitter model that drives the receive line
module serial_tx_model (
    input wire logic sys_clk,
    input wire logic sampleTick,
    output logic rxLine
);
    timeunit 1ns;
    timeprecision 1ns;

    // Line idles high between frames
    initial rxLine = 1'b1;

    task automatic waitTicks(input int n);
        repeat (n) @(posedge sys_clk iff sampleTick);
        @(negedge sys_clk);
    endtask : waitTicks

    // Bits go LSB first, start bit at position 0, then a short idle
    task automatic sendFrame(input logic [11:0] bits, input int len,
                             input int spb);
        for (int i = 0; i < len; i++) begin
            rxLine = bits[i];
            waitTicks(spb);
        end
        rxLine = 1'b1;
        waitTicks(2);
    endtask : sendFrame

    // Short low pulse that must not pass for a start bit
    task automatic glitch(input int n);
        rxLine = 1'b0;
        waitTicks(n);
        rxLine = 1'b1;
        waitTicks(32);
    endtask : glitch
endmodule : serial_tx_model

// >>> bench/uart_rx_buffer_status_bench.sv
// Self-checking bench of the serial receive block
module uart_rx_buffer_status_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import uart_rx_pkg::*;

    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic rxLine;
    logic sampleTick = 1'b0;
    rx_config_t cfg = '0;
    // Software side never writes the error flag positions
    logic globalIrqEn = 1'b0;
    logic dataRead = 1'b0;
    rx_entry_t rxHead;
    logic rxDoneFlag;
    logic rxIrq;
    logic pinOverride;
    rx_entry_t expQ[$];
    int errors = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h000131b8;

    always #50 sys_clk = ~sys_clk;
    // Tick every other cycle so an ignored tick shows as a bad rate
    always @(negedge sys_clk) sampleTick <= ~sampleTick;

    uart_rx_buffer_status u_uart_rx_buffer_status (
        .sys_clk(sys_clk), .rst_n(rst_n), .rxLine(rxLine),
        .sampleTick(sampleTick), .cfg(cfg), .globalIrqEn(globalIrqEn),
        .dataRead(dataRead), .rxHead(rxHead), .rxDoneFlag(rxDoneFlag),
        .rxIrq(rxIrq), .pinOverride(pinOverride)
    );

    serial_tx_model u_serial_tx_model (
        .sys_clk(sys_clk), .sampleTick(sampleTick), .rxLine(rxLine)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [8:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[8:0];
    endfunction : lfsr

    task automatic check(input logic [11:0] seen, input logic [11:0] exp,
                         input string msg);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    // Frame built from the current settings; the note goes in the queue only when keep is set
    task automatic sendChar(input logic [8:0] d, input logic flip,
                            input logic stopBit, input logic ovr,
                            input logic keep);
        logic [11:0] f;
        int nb;
        int pos;
        rx_entry_t e;
        nb = (cfg.charSizeSelect == CHAR_SIZE_NINE) ? 9 :
             5 + int'(cfg.charSizeSelect[1:0]);
        f = '1;
        f[0] = 1'b0;
        e = ENTRY_RESET;
        for (int i = 0; i < nb; i++) begin
            f[1 + i] = d[i];
            if (i < 8) e.data[i] = d[i];
        end
        pos = nb + 1;
        if (cfg.parityEnable) begin
            f[pos] = ^e.data ^ (nb == 9 && d[8]) ^ cfg.parityOdd ^ flip;
            pos++;
        end
        f[pos] = stopBit;
        e.ninth = (nb == 9) && d[8];
        e.frameErr = ~stopBit;
        e.overrun = ovr;
        e.parityErr = cfg.parityEnable & flip;
        if (keep) expQ.push_back(e);
        u_serial_tx_model.sendFrame(f, pos + 1, cfg.doubleSpeed ? 8 : 16);
    endtask : sendChar

    // Read until empty, twice, so a held frame moving in late is caught
    task automatic drain(input string name);
        repeat (2) begin
            while (rxDoneFlag === 1'b1) begin
                dataRead = 1'b1;
                @(negedge sys_clk);
            end
            dataRead = 1'b0;
            repeat (4) @(negedge sys_clk);
        end
        check(12'(expQ.size()), 12'h0, "frames missing");
        check(rxDoneFlag, 1'b0, "done flag after drain");
        check(rxIrq, 1'b0, "irq after reads");
        $display("test %s done", name);
    endtask : drain

    // Every read takes the oldest note and compares the visible entry
    always @(posedge sys_clk) begin
        if (dataRead && rxDoneFlag === 1'b1) begin
            if (expQ.size() == 0) check(12'h0, 12'h1, "extra");
            else check(rxHead, expQ.pop_front(),
                       "entry");
        end
    end

    initial begin
        #3ms;
        errors++;
        $display("CHECK FAILED at %0t: timeout", $time);
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        cfg.receiverEnable = 1'b1;
        cfg.charSizeSelect = 3'h3;
        repeat (2) @(negedge sys_clk);
        check(pinOverride, 1'b1, "pin owned");
        sendChar(lfsr(), 1'b0, 1'b1, 1'b0, 1'b1);
        sendChar(lfsr(), 1'b0, 1'b0, 1'b0, 1'b1);
        check(rxDoneFlag, 1'b1, "done flag");
        for (int i = 0; i < 4; i++) begin
            cfg.rxDoneIrqEn = i[0];
            globalIrqEn = i[1];
            repeat (2) @(negedge sys_clk);
            check(rxIrq, i[0] & i[1], "irq level");
        end
        drain("basic");
        cfg.charSizeSelect = CHAR_SIZE_NINE;
        cfg.parityEnable = 1'b1;
        for (int i = 0; i < 4; i++) begin
            cfg.parityOdd = i[1];
            sendChar(lfsr(), i[0], 1'b1, 1'b0, 1'b1);
            if (i[0]) drain("parity");
        end
        cfg.parityEnable = 1'b0;
        for (int i = 0; i < 4; i++) begin
            cfg.charSizeSelect = 3'(i);
            sendChar(lfsr(), 1'b0, i[0], 1'b0, 1'b1);
            drain("size and stop");
        end
        cfg.charSizeSelect = 3'h6;
        cfg.doubleSpeed = 1'b1;
        sendChar(lfsr(), 1'b0, 1'b1, 1'b0, 1'b1);
        sendChar(lfsr(), 1'b0, 1'b0, 1'b0, 1'b1);
        drain("double speed");
        cfg.doubleSpeed = 1'b0;
        u_serial_tx_model.glitch(6);
        check(rxDoneFlag, 1'b0, "spike ignored");
        $display("test noise done");
        for (int i = 0; i < 4; i++) begin
            sendChar(lfsr(), 1'b0, 1'b1, i == 3, i != 2);
        end
        drain("overrun");
        sendChar(lfsr(), 1'b0, 1'b1, 1'b0, 1'b1);
        drain("overrun cleared");
        sendChar(lfsr(), 1'b0, 1'b1, 1'b0, 1'b0);
        cfg.receiverEnable = 1'b0;
        repeat (2) @(negedge sys_clk);
        check(rxDoneFlag, 1'b0, "flushed");
        check(pinOverride, 1'b0, "pin released");
        cfg.receiverEnable = 1'b1;
        // High data bits keep the re-enabled receiver from seeing a start
        fork
            sendChar(9'h0ff, 1'b0, 1'b1, 1'b0, 1'b0);
            begin
                repeat (200) @(negedge sys_clk);
                cfg.receiverEnable = 1'b0;
                repeat (2) @(negedge sys_clk);
                cfg.receiverEnable = 1'b1;
            end
        join
        check(rxDoneFlag, 1'b0, "frame abandoned");
        drain("disable");
        test_done();
    end
endmodule : uart_rx_buffer_status_bench
